//--- mpni_pkg.sv
`default_nettype none
package mpni_pkg;
   localparam int MPNI_AW = 8;
   localparam logic [7:0] MPNI_ADDR_CTRL = 8'h00;
   localparam logic [7:0] MPNI_ADDR_STAT = 8'h04;
   localparam int MPNI_CTRL_W = 4;
   localparam int MPNI_C_SERIAL = 0;
   localparam int MPNI_C_LOOP = 1;
   localparam int MPNI_C_NOMATCH = 2;
   localparam int MPNI_C_POL = 3;
   localparam logic [3:0] MPNI_CTRL_RST = 4'h0;
   localparam int MPNI_S_CRS = 0;
   localparam int MPNI_S_COL = 1;
   localparam int MPNI_S_LINK = 2;
   localparam int MPNI_S_BUSY = 3;
   localparam int MPNI_S_PACKET_COMPRESS_STROBE = 4;
   localparam logic [1:0] MPNI_RESP_OKAY = 2'h0;
   localparam logic [1:0] MPNI_RESP_SLVERR = 2'h2;
   localparam logic [2:0] MPNI_NIB_LAST = 3'h1;
   localparam logic [2:0] MPNI_SER_LAST = 3'h7;
   localparam int MPNI_SYNC_W = 10;
   localparam int MPNI_I_TXC = 9;
   localparam int MPNI_I_RXC = 8;
   localparam int MPNI_I_RXD = 4;
   localparam int MPNI_I_DV = 3;
   localparam int MPNI_I_ER = 2;
   localparam int MPNI_I_CRS = 1;
   localparam int MPNI_I_COL = 0;
   typedef enum logic [0:0] {
      MPNI_TX_IDLE = 1'b0,
      MPNI_TX_SEND = 1'b1
   } mpni_tx_state_t;
endpackage
`default_nettype wire

//--- mpni_sync.sv
`timescale 1ns/10ps
`default_nettype none
module mpni_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   import mpni_pkg::*;
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } mpni_sync_st_t;
   mpni_sync_st_t s;
   mpni_sync_st_t next_s;

   // First stage feeds only the second
   always_comb begin
      next_s.s1 = d;
      next_s.s2 = s.s1;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign q = s.s2;

   property p_two_stage;
      @(posedge clock) disable iff (rst)
      $past(!rst, 2) |-> q == $past(d, 2);
   endproperty
   a_two_stage: assert property (p_two_stage) else $error("sync delay is not two");
endmodule
`default_nettype wire

//--- mpni_rx_asm.sv
`timescale 1ns/10ps
`default_nettype none
module mpni_rx_asm (
   input wire logic clock,
   input wire logic rst,
   input wire logic step,
   input wire logic clr,
   input wire logic ser,
   input wire logic [3:0] bits,
   output logic [7:0] rx_data,
   output logic rx_valid
);
   import mpni_pkg::*;
   typedef struct packed {
      logic [2:0] cnt;
      logic [7:0] sh;
      logic [7:0] data;
      logic valid;
   } mpni_asm_st_t;
   mpni_asm_st_t s;
   mpni_asm_st_t next_s;
   logic [7:0] nb;
   logic [2:0] last;

   // Earliest bit lands in bit 0 in both modes
   assign nb = ser ? {bits[0], s.sh[7:1]} : {bits, s.sh[7:4]};
   assign last = ser ? MPNI_SER_LAST : MPNI_NIB_LAST;

   always_comb begin
      next_s = s;
      next_s.valid = 1'b0;
      if (clr) begin
         next_s.cnt = 3'h0;
      end else if (step) begin
         next_s.sh = nb;
         next_s.cnt = s.cnt + 3'h1;
         if (s.cnt == last) begin
            next_s.data = nb;
            next_s.valid = 1'b1;
            next_s.cnt = 3'h0;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign rx_data = s.data;
   assign rx_valid = s.valid;

   sequence s_first_nib;
      step && !clr && !ser && s.cnt == 3'h0;
   endsequence
   property p_nib_pair;
      logic [3:0] lo;
      @(posedge clock) disable iff (rst)
      first_match((s_first_nib, lo = bits) ##[1:16] (step || clr))
         |-> clr or (##1 (rx_valid && rx_data[3:0] == lo));
   endproperty
   a_nib_pair: assert property (p_nib_pair) else $error("first nibble not low half");
endmodule
`default_nettype wire

//--- mpni_top.sv
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Transmit nibbles: low nibble of each byte first, high nibble next clock.
// - Serial mode: serial transmit bits go out on transmit data bit 0.
// - Serial mode: transmit data bit 1 carries the loop-back control bit.
// - Transmit enable is high exactly while transmit nibbles carry frame data.
// - Serial mode: serial transmit enable rises once frame data is ready.
// - Transmit error is driven synchronous to the transmit clock.
// - Serial mode: compression output asserts right after destination address intake.
// - Software picks compression on address-filter match or on no match.
// - Software picks the active polarity of the compression output.
// - PHY changes receive pins on falling edge; device samples on rising edge.
// - Received nibbles assemble earliest first: first nibble is the low half.
// - Serial mode: serial receive bits are taken from receive data bit 0.
// - Transmit nibbles and enable update on the transmit clock rising edge.
module mpni_top (
   input wire logic clock,
   input wire logic rst,
   input wire logic [mpni_pkg::MPNI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [mpni_pkg::MPNI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic tx_err_req,
   input wire logic da_done,
   input wire logic da_match,
   output logic [7:0] rx_data,
   output logic rx_valid,
   output logic rx_frame_end,
   output logic rx_err,
   input wire logic phy_tx_clk,
   input wire logic phy_rx_clk,
   input wire logic [3:0] phy_rxd,
   input wire logic phy_rx_dv,
   input wire logic phy_rx_er,
   input wire logic phy_crs,
   input wire logic phy_col,
   output logic [3:0] phy_txd,
   output logic phy_tx_en,
   output logic phy_tx_err
);
   import mpni_pkg::*;

   typedef struct packed {
      logic aw_got;
      logic w_got;
      logic [MPNI_AW-1:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [MPNI_CTRL_W-1:0] ctrl;
      logic txc_d;
      logic rxc_d;
      mpni_tx_state_t txs;
      logic [2:0] cnt;
      logic [7:0] sh;
      logic [3:0] txd;
      logic tx_en;
      logic tx_err;
      logic err_pin;
      logic packet_compress_strobe;
      logic rx_act;
      logic frame_end;
      logic rx_err;
   } mpni_st_t;

   mpni_st_t s;
   mpni_st_t next_s;
   logic [MPNI_SYNC_W-1:0] sy;
   logic ser;
   logic tx_edge;
   logic rx_edge;
   logic need;
   logic valid_now;
   logic [2:0] last;
   logic [31:0] stat_word;

   // Clock pins are sampled like data; edges found in the system clock domain
   mpni_sync #(
      .WIDTH(MPNI_SYNC_W)
   ) u_sync (
      .clock(clock),
      .rst(rst),
      .d({phy_tx_clk, phy_rx_clk, phy_rxd, phy_rx_dv, phy_rx_er, phy_crs, phy_col}),
      .q(sy)
   );

   assign ser = s.ctrl[MPNI_C_SERIAL];
   assign tx_edge = sy[MPNI_I_TXC] & ~s.txc_d;
   assign rx_edge = sy[MPNI_I_RXC] & ~s.rxc_d;
   assign last = ser ? MPNI_SER_LAST : MPNI_NIB_LAST;
   assign need = (s.txs == MPNI_TX_IDLE) || (s.cnt == last);
   // Serial frames are bounded by serial carrier sense; the shared valid pin is link
   assign valid_now = ser ? sy[MPNI_I_CRS] : sy[MPNI_I_DV];
   assign tx_ready = tx_edge & need;

   always_comb begin
      stat_word = 32'h0;
      stat_word[MPNI_S_CRS] = sy[MPNI_I_CRS];
      stat_word[MPNI_S_COL] = sy[MPNI_I_COL];
      stat_word[MPNI_S_LINK] = sy[MPNI_I_DV];
      stat_word[MPNI_S_BUSY] = s.tx_en;
      stat_word[MPNI_S_PACKET_COMPRESS_STROBE] = s.packet_compress_strobe;
   end

   always_comb begin
      next_s = s;
      next_s.txc_d = sy[MPNI_I_TXC];
      next_s.rxc_d = sy[MPNI_I_RXC];
      // Register bus, write side
      if (s_axi_awvalid && s_axi_awready) begin
         next_s.aw_got = 1'b1;
         next_s.waddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_s.w_got = 1'b1;
         next_s.wdata = s_axi_wdata;
         next_s.wstrb = s_axi_wstrb;
      end
      if (s.aw_got && s.w_got) begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = MPNI_RESP_OKAY;
         if (s.waddr == MPNI_ADDR_CTRL) begin
            if (s.wstrb[0]) begin
               next_s.ctrl = s.wdata[MPNI_CTRL_W-1:0];
            end
         end else if (s.waddr != MPNI_ADDR_STAT) begin
            next_s.bresp = MPNI_RESP_SLVERR;
         end
      end
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end
      // Register bus, read side
      if (s_axi_arvalid && s_axi_arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = MPNI_RESP_OKAY;
         if (s_axi_araddr == MPNI_ADDR_CTRL) begin
            next_s.rdata = {{(32 - MPNI_CTRL_W){1'b0}}, s.ctrl};
         end else if (s_axi_araddr == MPNI_ADDR_STAT) begin
            next_s.rdata = stat_word;
         end else begin
            next_s.rdata = 32'h0;
            next_s.rresp = MPNI_RESP_SLVERR;
         end
      end
      if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end
      // Transmit: pin changes follow a transmit clock rising edge, except the serial loop-back bit
      if (tx_edge) begin
         next_s.tx_err = tx_err_req;
         if (need) begin
            if (tx_valid) begin
               next_s.txs = MPNI_TX_SEND;
               next_s.cnt = 3'h0;
               next_s.tx_en = 1'b1;
               if (ser) begin
                  next_s.txd[0] = tx_data[0];
                  next_s.sh = {1'b0, tx_data[7:1]};
               end else begin
                  next_s.txd = tx_data[3:0];
                  next_s.sh = {4'h0, tx_data[7:4]};
               end
            end else begin
               // Underrun ends the frame; upstream must keep bytes ready
               next_s.txs = MPNI_TX_IDLE;
               next_s.tx_en = 1'b0;
               next_s.txd = 4'h0;
            end
         end else begin
            next_s.cnt = s.cnt + 3'h1;
            if (ser) begin
               next_s.txd[0] = s.sh[0];
               next_s.sh = {1'b0, s.sh[7:1]};
            end else begin
               next_s.txd = s.sh[3:0];
               next_s.sh = {4'h0, s.sh[7:4]};
            end
         end
      end
      if (ser) begin
         // Loop-back request tracks the control bit at all times
         next_s.txd[1] = s.ctrl[MPNI_C_LOOP];
         next_s.txd[3:2] = 2'h0;
      end
      // Receive framing
      next_s.frame_end = 1'b0;
      next_s.rx_err = 1'b0;
      if (rx_edge) begin
         next_s.rx_act = valid_now;
         next_s.frame_end = s.rx_act & ~valid_now;
         next_s.rx_err = ~ser & sy[MPNI_I_DV] & sy[MPNI_I_ER];
      end
      // Compression strobe lives until the received frame ends or serial mode is left
      if (!ser || next_s.frame_end) begin
         next_s.packet_compress_strobe = 1'b0;
      end
      if (ser && da_done && (da_match ^ s.ctrl[MPNI_C_NOMATCH])) begin
         next_s.packet_compress_strobe = 1'b1;
      end
      // Shared pin: transmit error or compression strobe
      next_s.err_pin = ser ? (next_s.packet_compress_strobe ^ s.ctrl[MPNI_C_POL]) : next_s.tx_err;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s <= '0;
         s.ctrl <= MPNI_CTRL_RST;
         s.txs <= MPNI_TX_IDLE;
      end else begin
         s <= next_s;
      end
   end

   mpni_rx_asm u_rx_asm (
      .clock(clock),
      .rst(rst),
      .step(rx_edge & valid_now),
      .clr(rx_edge & ~valid_now),
      .ser(ser),
      .bits(sy[MPNI_I_RXD +: 4]),
      .rx_data(rx_data),
      .rx_valid(rx_valid)
   );

   assign s_axi_awready = ~s.aw_got & ~s.bvalid;
   assign s_axi_wready = ~s.w_got & ~s.bvalid;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = ~s.rvalid;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign phy_txd = s.txd;
   assign phy_tx_en = s.tx_en;
   assign phy_tx_err = s.err_pin;
   assign rx_frame_end = s.frame_end;
   assign rx_err = s.rx_err;

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence s_take_nib;
      tx_ready && tx_valid && !ser;
   endsequence

   property p_nib_lo;
      s_take_nib |=> phy_txd == $past(tx_data[3:0]);
   endproperty
   a_nib_lo: assert property (p_nib_lo) else $error("low nibble not sent first");

   property p_nib_hi;
      logic [3:0] h;
      first_match((s_take_nib, h = tx_data[7:4]) ##[1:16] tx_edge)
         |=> ser || phy_txd == h;
   endproperty
   a_nib_hi: assert property (p_nib_hi) else $error("high nibble not sent second");

   property p_ser_bit;
      tx_ready && tx_valid && ser |=> phy_txd[0] == $past(tx_data[0]);
   endproperty
   a_ser_bit: assert property (p_ser_bit) else $error("serial first bit wrong");

   property p_loop;
      $past(ser) && ser |-> phy_txd[1] == $past(s.ctrl[MPNI_C_LOOP]);
   endproperty
   a_loop: assert property (p_loop) else $error("loop-back line wrong");

   property p_en_rise;
      $rose(phy_tx_en) |-> $past(tx_ready && tx_valid);
   endproperty
   a_en_rise: assert property (p_en_rise) else $error("enable rose without data");

   property p_en_fall;
      $fell(phy_tx_en) |-> $past(tx_ready && !tx_valid);
   endproperty
   a_en_fall: assert property (p_en_fall) else $error("enable fell mid byte");

   property p_tx_edge;
      $changed(phy_tx_en) || (!ser && $past(!ser) && $changed(phy_txd)) |-> $past(tx_edge);
   endproperty
   a_tx_edge: assert property (p_tx_edge) else $error("transmit pins moved off edge");

   property p_err_sync;
      // Leaving serial mode swaps the pin source one cycle late
      !ser && $past(!ser) && !$past(ser, 2) && $changed(phy_tx_err) |-> $past(tx_edge);
   endproperty
   a_err_sync: assert property (p_err_sync) else $error("transmit error off edge");

   property p_packet_compress_strobe;
      ser && da_done && (da_match != s.ctrl[MPNI_C_NOMATCH]) && $stable(s.ctrl)
         |=> s.packet_compress_strobe && phy_tx_err == !s.ctrl[MPNI_C_POL];
   endproperty
   a_packet_compress_strobe: assert property (p_packet_compress_strobe) else $error("compression strobe missed");

   property p_pol;
      $past(ser) && $stable(s.ctrl) |-> phy_tx_err == (s.packet_compress_strobe ^ s.ctrl[MPNI_C_POL]);
   endproperty
   a_pol: assert property (p_pol) else $error("compression polarity wrong");
endmodule
`default_nettype wire

//--- mpni_phy_model.sv
`timescale 1ns/10ps
`default_nettype none
module mpni_phy_model (
   output logic phy_tx_clk,
   output logic phy_rx_clk,
   output logic [3:0] phy_rxd,
   output logic phy_rx_dv,
   output logic phy_rx_er,
   output logic phy_crs,
   output logic phy_col,
   input wire logic [3:0] phy_txd,
   input wire logic phy_tx_en,
   input wire logic phy_tx_err
);
   logic [3:0] cap_q[$];
   int err_seen;
   // Free-running clocks, phases unrelated to the system clock
   initial begin
      phy_tx_clk = 1'b0;
      #7;
      forever #80 phy_tx_clk = ~phy_tx_clk;
   end
   initial begin
      phy_rx_clk = 1'b0;
      #33;
      forever #80 phy_rx_clk = ~phy_rx_clk;
   end
   initial begin
      phy_rxd = 4'h5;
      phy_rx_dv = 1'b0;
      phy_rx_er = 1'b0;
      phy_crs = 1'b0;
      phy_col = 1'b0;
      err_seen = 0;
   end
   always @(posedge phy_tx_clk) begin
      if (phy_tx_en)
         cap_q.push_back(phy_txd);
      if (phy_tx_err)
         err_seen++;
   end
   task automatic rx_frame(input logic [7:0] d[$], input logic ser, input int er_at);
      int n;
      n = ser ? 8 : 2;
      foreach (d[i]) begin
         for (int k = 0; k < n; k++) begin
            @(negedge phy_rx_clk);
            phy_rxd <= ser ? {~phy_rxd[3:1], d[i][k]} : d[i][4*k +: 4];
            phy_rx_dv <= !ser;
            phy_rx_er <= !ser && i == er_at;
            phy_crs <= 1'b1;
         end
      end
      // Released data shows the inverse, never a stale copy
      @(negedge phy_rx_clk);
      phy_rxd <= ~phy_rxd;
      phy_rx_dv <= 1'b0;
      phy_rx_er <= 1'b0;
      phy_crs <= 1'b0;
   endtask
   task automatic set_col(input logic v);
      phy_col <= v;
   endtask
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import mpni_pkg::*;
   logic clock, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [MPNI_AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, phy_rxd, phy_txd;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] tx_data, rx_data;
   logic tx_valid, tx_ready, tx_err_req, da_done, da_match, rx_valid, rx_frame_end, rx_err;
   logic phy_tx_clk, phy_rx_clk, phy_rx_dv, phy_rx_er, phy_crs, phy_col, phy_tx_en, phy_tx_err;
   logic [7:0] rxq[$];
   int n_mismatch = 0;
   int tests_run = 0;
   int n_err, n_end;
   mpni_top mpni_top_i (.*);
   mpni_phy_model mpni_phy_model_i (.*);
   always #10 clock = ~clock;
   always @(posedge clock) begin
      if (rx_valid)
         rxq.push_back(rx_data);
      if (rx_err)
         n_err++;
      if (rx_frame_end)
         n_end++;
   end
   task automatic fail(input string m);
      n_mismatch++;
      $display("mismatch %0t %s", $time, m);
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      tests_run++;
      if (g !== e)
         fail(m);
   endtask
   task automatic finish_test;
      if (n_mismatch == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
      logic ta, tw, da, dw;
      int t;
      da = 0;
      dw = 0;
      t = 0;
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(da && dw) && t < 100) begin
         @(negedge clock);
         t++;
         ta = !da && s_axi_awready;
         tw = !dw && s_axi_wready;
         @(posedge clock);
         if (ta)
            s_axi_awvalid <= 1'b0;
         if (tw)
            s_axi_wvalid <= 1'b0;
         da = da | ta;
         dw = dw | tw;
      end
      do @(negedge clock); while (!s_axi_bvalid && ++t < 100);
      rs = s_axi_bresp;
      @(posedge clock);
      s_axi_bready <= 1'b0;
      if (t >= 100)
         fail("write timeout");
   endtask
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
      int t;
      t = 0;
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(negedge clock); while (!s_axi_arready && ++t < 100);
      @(posedge clock);
      s_axi_arvalid <= 1'b0;
      do @(negedge clock); while (!s_axi_rvalid && ++t < 100);
      d = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clock);
      s_axi_rready <= 1'b0;
      if (t >= 100)
         fail("read timeout");
   endtask
   task automatic tx_frame(input logic [7:0] d[$], input logic ser, input logic lp);
      int i, t, n;
      logic [3:0] e;
      mpni_phy_model_i.cap_q.delete();
      i = 0;
      t = 0;
      n = ser ? 8 : 2;
      @(posedge clock);
      tx_data <= d[0];
      tx_valid <= 1'b1;
      while (i < d.size() && t < 5000) begin
         @(negedge clock);
         t++;
         if (tx_ready) begin
            @(posedge clock);
            i++;
            if (i == d.size())
               tx_valid <= 1'b0;
            else
               tx_data <= d[i];
         end
      end
      // Frame closes at the next transmit slot, then enable falls
      do @(negedge clock); while (phy_tx_en && ++t < 5000);
      if (t >= 5000)
         fail("tx timeout");
      chk(32'(mpni_phy_model_i.cap_q.size()), 32'(d.size() * n), "tx unit count");
      for (int j = 0; j < mpni_phy_model_i.cap_q.size(); j++) begin
         e = ser ? {2'h0, lp, d[j/8][j%8]} : d[j/2][4*(j%2) +: 4];
         chk(32'(mpni_phy_model_i.cap_q[j]), 32'(e), "tx unit");
      end
   endtask
   task automatic rx_check(input logic [7:0] d[$], input logic ser, input int er_at);
      rxq.delete();
      n_err = 0;
      n_end = 0;
      mpni_phy_model_i.rx_frame(d, ser, er_at);
      repeat (20) @(posedge clock);
      chk(32'(rxq.size()), 32'(d.size()), "rx byte count");
      foreach (d[i])
         chk(32'(rxq[i]), 32'(d[i]), "rx byte");
      chk(32'(n_end), 32'h1, "rx frame end");
      chk(32'(n_err), (er_at >= 0 && !ser) ? 32'h2 : 32'h0, "rx error");
   endtask
   task automatic da_pulse(input logic m);
      @(posedge clock);
      da_done <= 1'b1;
      da_match <= m;
      @(posedge clock);
      da_done <= 1'b0;
      repeat (2) @(posedge clock);
      @(negedge clock);
   endtask
   initial begin
      #1_000_000;
      fail("watchdog");
      finish_test;
   end
   initial begin
      logic [7:0] d[$];
      logic [31:0] r;
      logic [1:0] rs;
      logic nm, pol, m;
      {clock, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, tx_data, tx_valid, tx_err_req} = '0;
      {da_done, da_match} = '0;
      s_axi_wstrb = 4'hf;
      rst = 1'b1;
      void'($urandom(89279));
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      axi_read(MPNI_ADDR_CTRL, r, rs);
      chk(r, 32'(MPNI_CTRL_RST), "ctrl reset");
      axi_read(8'h08, r, rs);
      chk(r, 32'h0, "unmapped read data");
      chk(32'(rs), 32'(MPNI_RESP_SLVERR), "unmapped read resp");
      axi_write(MPNI_ADDR_STAT, 32'hffff_ffff, rs);
      chk(32'(rs), 32'(MPNI_RESP_OKAY), "status write");
      axi_write(MPNI_ADDR_CTRL, 32'h5a, rs);
      axi_read(MPNI_ADDR_CTRL, r, rs);
      chk(r, 32'ha, "ctrl readback");
      axi_write(MPNI_ADDR_CTRL, 32'h0, rs);
      d = {8'h0f, 8'hf0};
      repeat (1 + $urandom % 4) d.push_back(8'($urandom));
      tx_frame(d, 1'b0, 1'b0);
      chk(32'(mpni_phy_model_i.err_seen), 32'h0, "no tx error");
      @(posedge clock);
      tx_err_req <= 1'b1;
      tx_frame({8'ha5}, 1'b0, 1'b0);
      @(posedge clock);
      tx_err_req <= 1'b0;
      chk(32'(mpni_phy_model_i.err_seen != 0), 32'h1, "tx error seen");
      rx_check(d, 1'b0, -1);
      rx_check({8'($urandom), 8'h3c, 8'($urandom)}, 1'b0, 1);
      axi_write(MPNI_ADDR_CTRL, 32'h3, rs);
      tx_frame(d, 1'b1, 1'b1);
      axi_write(MPNI_ADDR_CTRL, 32'h1, rs);
      tx_frame({8'h81}, 1'b1, 1'b0);
      da_pulse(1'b1);
      chk(32'(phy_tx_err), 32'h1, "compress set");
      rx_check(d, 1'b1, -1);
      chk(32'(phy_tx_err), 32'h0, "compress cleared");
      for (int c = 0; c < 8; c++) begin
         {m, pol, nm} = 3'(c);
         axi_write(MPNI_ADDR_CTRL, 32'h0, rs);
         axi_write(MPNI_ADDR_CTRL, {28'h0, pol, nm, 2'h1}, rs);
         repeat (4) @(negedge clock);
         chk(32'(phy_tx_err), 32'(pol), "compress idle");
         da_pulse(m);
         chk(32'(phy_tx_err), 32'(pol ^ (m ^ nm)), "compress level");
      end
      // Last setting leaves the strobe idle, so only collision shows
      @(posedge clock);
      mpni_phy_model_i.set_col(1'b1);
      repeat (4) @(posedge clock);
      axi_read(MPNI_ADDR_STAT, r, rs);
      chk(r, 32'h1 << MPNI_S_COL, "status word");
      finish_test;
   end
endmodule
`default_nettype wire
